// ---- hdl/sbc_cfg.svh ----
// constants of the serial byte configuration port
`ifndef SBC_CFG_SVH
`define SBC_CFG_SVH

// ****************************************************************
// serial protocol
// ****************************************************************
`define SBC_SLAVE_ADDR 7'h69
`define SBC_LAST_BIT 3'h7
`define SBC_BIT_ZERO 3'h0
`define SBC_CMD_BYTE_OP 7
`define SBC_RW_BIT 0
`define SBC_IDX_BYTE0 7'h00
`define SBC_IDX_BYTE1 7'h01
`define SBC_IDX_BYTE2 7'h02
`define SBC_UNMAPPED_DATA 8'h00

// ****************************************************************
// configuration bytes: reset, writable mask, fixed reserved values
// ****************************************************************
`define SBC_B0_RST 8'h4C
`define SBC_B0_WMASK 8'h40
`define SBC_B0_FIXED 8'h0C
`define SBC_B1_RST 8'h7F
`define SBC_B1_WMASK 8'hC7
`define SBC_B1_FIXED 8'h38
`define SBC_B2_RST 8'h00
`define SBC_B2_WMASK 8'hF8
`define SBC_B2_FIXED 8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define SBC_B0_DRIVE 6
`define SBC_B0_STRAP_SECOND 1
`define SBC_B0_STRAP_FIRST 0
`define SBC_B1_SRC_STOPPABLE 7
`define SBC_B1_SRC_EN 6
`define SBC_B1_CPU_EN_LSB 0
`define SBC_B2_SRC_PD_TRI 7
`define SBC_B2_SRC_STOP_TRI 6
`define SBC_B2_CPU_PD_TRI_LSB 3

// ****************************************************************
// timing: ref_clk cycles after reset before straps are caught
// ****************************************************************
`define SBC_STRAP_WAIT 2'h3

`endif

// ---- hdl/sbc_config_port.sv ----
// serial byte configuration port of the clock synthesizer
//
// Operation
// [R1] host write: start, address, write bit 0, command, one data, stop
// [R2] device acks address, command and data byte, then stores data
// [R3] command 100xxxxx is a byte op; low seven bits index the byte
// [R4] byte read: repeated start, address read bit 1, ack, indexed byte
// [R5] host acks or nacks the read byte then sends stop
// [R6] byte 0 bit 6 sets bus clock drive strength, resets to 1
// [R7] byte 0 bits 1,0 read the straps caught at power-up
// [R8] byte 1 bit 7 lets software stop halt the serial reference pair
// [R9] byte 1 bit 6 enables serial reference pair, resets to 1
// [R10] byte 1 bits 2..0 enable debug, pair1, pair0 cpu clocks
// [R11] byte 2 bit 7 three-states serial reference pair in power down
// [R12] byte 2 bit 6 three-states serial reference pair while stopped
// [R13] byte 2 bits 5..3 three-state cpu pairs in power down
// [R14] device answers only address bytes 1101001x
// [R15] command bit 7 at 0 is a block op, not handled here
// [R16] software stop halts and resumes bus clocks glitch free
// [R17] host writes reserved bits with their fixed values
// [R18] writable bits return to defaults at power-up
`timescale 1ns/1ns
`include "sbc_cfg.svh"

module sbc_config_port (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic smb_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic freq_strap_first,
    input wire logic freq_strap_second,
    input wire logic power_down,
    input wire logic software_bus_clock_stop,
    output sbc_pkg::sbc_clk_ctl_t clk_ctl
);

    // ************************************************************
    // functions
    // ************************************************************

    // writable bits from the host, reserved bits at their fixed value
    function automatic logic [7:0] wr_merge(input logic [7:0] data,
                                            input logic [7:0] mask,
                                            input logic [7:0] fixed);
        wr_merge = (data & mask) | (fixed & ~mask);
    endfunction

    // ************************************************************
    // declarations
    // ************************************************************
    sbc_pkg::sbc_state_t state_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] rx_reg;
    logic [7:0] tx_reg;
    logic read_reg;
    logic sda_oe_reg;
    logic [6:0] index_reg;
    logic [7:0] cfg0_reg;
    logic [7:0] cfg1_reg;
    logic [7:0] cfg2_reg;
    logic [1:0] strap_scl;
    logic [7:0] rx_byte;
    logic [6:0] cmd_idx;
    logic [7:0] rd_data;
    logic byte_done;
    logic link_rst_b;
    sbc_pkg::sbc_cfg_t cfg_word;
    sbc_pkg::sbc_cfg_t cfg_s;
    logic [5:0] pin_s;
    logic scl_s;
    logic sda_s;
    logic pd_s;
    logic stop_s;
    logic scl_prev_reg;
    logic sda_prev_reg;
    logic bus_evt_reg;
    logic [1:0] strap_wait_reg;
    logic [1:0] strap_reg;
    sbc_pkg::sbc_clk_ctl_t clk_ctl_reg;

    // ************************************************************
    // reference clock side: pin synchronisers and bus conditions
    // ************************************************************
    sbc_sync2 #(.WIDTH(6)) u_pin_sync (
        .clk(ref_clk),
        .rst_b(rst_b),
        .d({smb_clk, sda_in, power_down, software_bus_clock_stop,
            freq_strap_second, freq_strap_first}),
        .q(pin_s)
    );

    assign scl_s = pin_s[5];
    assign sda_s = pin_s[4];
    assign pd_s = pin_s[3];
    assign stop_s = pin_s[2];

    // start and stop seen as sda edges while scl stays high
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            bus_evt_reg <= 1'b0;
        end else begin
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
            bus_evt_reg <= scl_s & scl_prev_reg & (sda_s ^ sda_prev_reg);
        end
    end

    // a start or stop restarts the link engine; the pulse is a flop
    // output so the reset it forms is glitch free
    assign link_rst_b = rst_b & ~bus_evt_reg;

    // straps caught once the pin synchroniser has filled after reset
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_wait_reg <= 2'h0;
            strap_reg <= 2'h0;
        end else if (strap_wait_reg != `SBC_STRAP_WAIT) begin
            strap_wait_reg <= strap_wait_reg + 2'h1;
            if (strap_wait_reg == `SBC_STRAP_WAIT - 2'h1) begin
                strap_reg <= pin_s[1:0]; // [R7]
            end
        end
    end

    // ************************************************************
    // link side: bit engine on the serial clock
    // ************************************************************
    assign rx_byte = {rx_reg[6:0], sda_in};
    assign cmd_idx = rx_byte[6:0];
    assign byte_done = (bit_cnt_reg == `SBC_LAST_BIT);

    // transaction sequencing, bits sampled on rising scl
    always_ff @(posedge smb_clk or negedge link_rst_b) begin
        if (!link_rst_b) begin
            state_reg <= sbc_pkg::ST_ADDR;
            bit_cnt_reg <= `SBC_BIT_ZERO;
            rx_reg <= 8'h00;
            read_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                sbc_pkg::ST_ADDR: begin
                    rx_reg <= rx_byte;
                    bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    if (byte_done) begin
                        if (rx_byte[7:1] == `SBC_SLAVE_ADDR) begin // [R14]
                            state_reg <= sbc_pkg::ST_ADDR_ACK;
                            read_reg <= rx_byte[`SBC_RW_BIT]; // [R1] [R4]
                        end else begin
                            state_reg <= sbc_pkg::ST_IGNORE;
                        end
                    end
                end
                sbc_pkg::ST_ADDR_ACK: begin
                    bit_cnt_reg <= `SBC_BIT_ZERO;
                    state_reg <= read_reg ? sbc_pkg::ST_RDATA
                                          : sbc_pkg::ST_CMD;
                end
                sbc_pkg::ST_CMD: begin
                    rx_reg <= rx_byte;
                    bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    if (byte_done) begin
                        // block operations are refused with a nack
                        state_reg <= rx_byte[`SBC_CMD_BYTE_OP] ?
                            sbc_pkg::ST_CMD_ACK : sbc_pkg::ST_IGNORE; // [R15]
                    end
                end
                sbc_pkg::ST_CMD_ACK: begin
                    bit_cnt_reg <= `SBC_BIT_ZERO;
                    state_reg <= sbc_pkg::ST_WDATA;
                end
                sbc_pkg::ST_WDATA: begin
                    rx_reg <= rx_byte;
                    bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    if (byte_done) begin
                        state_reg <= sbc_pkg::ST_WDATA_ACK;
                    end
                end
                sbc_pkg::ST_WDATA_ACK: begin
                    // only one byte per write; extra bytes get a nack
                    state_reg <= sbc_pkg::ST_IGNORE;
                end
                sbc_pkg::ST_RDATA: begin
                    bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    if (byte_done) begin
                        state_reg <= sbc_pkg::ST_RDATA_ACK;
                    end
                end
                sbc_pkg::ST_RDATA_ACK: begin
                    state_reg <= sbc_pkg::ST_IGNORE; // [R5]
                end
                sbc_pkg::ST_IGNORE: begin
                    state_reg <= sbc_pkg::ST_IGNORE;
                end
            endcase
        end
    end

    // read byte assembly: reserved bits read their fixed values
    always_comb begin
        unique case (index_reg)
            `SBC_IDX_BYTE0: rd_data = {cfg0_reg[7:2], strap_scl}; // [R7]
            `SBC_IDX_BYTE1: rd_data = cfg1_reg;
            `SBC_IDX_BYTE2: rd_data = cfg2_reg;
            default: rd_data = `SBC_UNMAPPED_DATA;
        endcase
    end

    // transmit shifter, loaded at the address ack of a read
    always_ff @(posedge smb_clk or negedge link_rst_b) begin
        if (!link_rst_b) begin
            tx_reg <= 8'h00;
        end else if (state_reg == sbc_pkg::ST_ADDR_ACK && read_reg) begin
            tx_reg <= rd_data; // [R4]
        end else if (state_reg == sbc_pkg::ST_RDATA) begin
            tx_reg <= {tx_reg[6:0], 1'b0};
        end
    end

    // sda changes on falling scl: ack low, or read data msb first;
    // a start or stop releases the line at once
    always_ff @(negedge smb_clk or negedge link_rst_b) begin
        if (!link_rst_b) begin
            sda_oe_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                sbc_pkg::ST_ADDR_ACK,
                sbc_pkg::ST_CMD_ACK,
                sbc_pkg::ST_WDATA_ACK: sda_oe_reg <= 1'b1; // [R2]
                sbc_pkg::ST_RDATA: sda_oe_reg <= ~tx_reg[7]; // [R4]
                sbc_pkg::ST_ADDR,
                sbc_pkg::ST_CMD,
                sbc_pkg::ST_WDATA,
                sbc_pkg::ST_RDATA_ACK,
                sbc_pkg::ST_IGNORE: sda_oe_reg <= 1'b0;
            endcase
        end
    end

    assign sda_oe = sda_oe_reg;
    assign sda_out = 1'b0;

    // byte index survives a repeated start, so only power-up clears it
    always_ff @(posedge smb_clk or negedge rst_b) begin
        if (!rst_b) begin
            index_reg <= `SBC_IDX_BYTE0;
        end else if (state_reg == sbc_pkg::ST_CMD && byte_done &&
                     rx_byte[`SBC_CMD_BYTE_OP]) begin
            index_reg <= cmd_idx; // [R3]
        end
    end

    // configuration bytes, written after the data ack; power-up only
    // reset so a start or stop never disturbs them
    always_ff @(posedge smb_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg0_reg <= `SBC_B0_RST; // [R18] [R6]
            cfg1_reg <= `SBC_B1_RST; // [R18] [R9] [R10]
            cfg2_reg <= `SBC_B2_RST; // [R18] [R11] [R13]
        end else if (state_reg == sbc_pkg::ST_WDATA_ACK) begin
            unique case (index_reg)
                `SBC_IDX_BYTE0: cfg0_reg <=
                    wr_merge(rx_reg, `SBC_B0_WMASK, `SBC_B0_FIXED); // [R2]
                `SBC_IDX_BYTE1: cfg1_reg <=
                    wr_merge(rx_reg, `SBC_B1_WMASK, `SBC_B1_FIXED); // [R2]
                `SBC_IDX_BYTE2: cfg2_reg <=
                    wr_merge(rx_reg, `SBC_B2_WMASK, `SBC_B2_FIXED); // [R2]
                default: ;
            endcase
        end
    end

    // ************************************************************
    // crossings between the two clocks
    // ************************************************************

    // straps are static after power-up; read back on the link clock
    sbc_sync2 #(.WIDTH(2)) u_strap_sync (
        .clk(smb_clk),
        .rst_b(rst_b),
        .d(strap_reg),
        .q(strap_scl)
    );

    // each configuration bit is an independent level, so a per-bit
    // synchroniser is enough; a write may land over two ref cycles
    assign cfg_word = '{b2: cfg2_reg, b1: cfg1_reg, b0: cfg0_reg};

    sbc_sync2 #(.WIDTH($bits(sbc_pkg::sbc_cfg_t))) u_cfg_sync (
        .clk(ref_clk),
        .rst_b(rst_b),
        .d(cfg_word),
        .q(cfg_s)
    );

    // ************************************************************
    // clock output controls
    // ************************************************************

    // all controls change only on a ref_clk edge, so the gates that
    // use them never cut a clock into a short pulse
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_ctl_reg <= '0;
        end else begin
            clk_ctl_reg.bus_drive_high <= cfg_s.b0[`SBC_B0_DRIVE]; // [R6]
            clk_ctl_reg.bus_clock_run <= ~stop_s; // [R16]
            clk_ctl_reg.src_run <=
                ~(stop_s & cfg_s.b1[`SBC_B1_SRC_STOPPABLE]); // [R8] [R16]
            clk_ctl_reg.src_oe <= cfg_s.b1[`SBC_B1_SRC_EN] // [R9]
                & ~(pd_s & cfg_s.b2[`SBC_B2_SRC_PD_TRI]) // [R11]
                & ~(stop_s & cfg_s.b1[`SBC_B1_SRC_STOPPABLE]
                    & cfg_s.b2[`SBC_B2_SRC_STOP_TRI]); // [R12]
            clk_ctl_reg.cpu_run <= ~pd_s;
            clk_ctl_reg.cpu_oe <=
                cfg_s.b1[`SBC_B1_CPU_EN_LSB +: 3] // [R10]
                & ~({3{pd_s}} & cfg_s.b2[`SBC_B2_CPU_PD_TRI_LSB +: 3]); // [R13]
        end
    end

    assign clk_ctl = clk_ctl_reg;

    // ************************************************************
    // assertions
    // ************************************************************
    property p_ack_drive;
        @(posedge smb_clk) disable iff (!link_rst_b)
        (state_reg inside {sbc_pkg::ST_ADDR_ACK, sbc_pkg::ST_CMD_ACK,
                           sbc_pkg::ST_WDATA_ACK}) |-> sda_oe_reg;
    endproperty
    a_ack_drive: assert property (p_ack_drive) // [R2]
        else $error("no ack driven in an ack slot");

    property p_addr_nack;
        @(posedge smb_clk) disable iff (!link_rst_b)
        (state_reg == sbc_pkg::ST_ADDR && byte_done &&
         rx_byte[7:1] != `SBC_SLAVE_ADDR)
        |=> state_reg == sbc_pkg::ST_IGNORE ##1 !sda_oe_reg;
    endproperty
    a_addr_nack: assert property (p_addr_nack) // [R14]
        else $error("foreign address not ignored");

    property p_block_refused;
        @(posedge smb_clk) disable iff (!link_rst_b)
        (state_reg == sbc_pkg::ST_CMD && byte_done &&
         !rx_byte[`SBC_CMD_BYTE_OP]) |=> state_reg == sbc_pkg::ST_IGNORE;
    endproperty
    a_block_refused: assert property (p_block_refused) // [R15]
        else $error("block command was accepted");

    property p_index_taken;
        @(posedge smb_clk) disable iff (!link_rst_b)
        (state_reg == sbc_pkg::ST_CMD && byte_done &&
         rx_byte[`SBC_CMD_BYTE_OP]) |=> index_reg == $past(cmd_idx);
    endproperty
    a_index_taken: assert property (p_index_taken) // [R3]
        else $error("byte index not taken from command");

    property p_store_byte1;
        @(posedge smb_clk) disable iff (!link_rst_b)
        (state_reg == sbc_pkg::ST_WDATA_ACK &&
         index_reg == `SBC_IDX_BYTE1) |=>
        cfg1_reg == wr_merge($past(rx_reg), `SBC_B1_WMASK, `SBC_B1_FIXED);
    endproperty
    a_store_byte1: assert property (p_store_byte1) // [R2]
        else $error("written byte not stored");

    property p_read_load;
        @(posedge smb_clk) disable iff (!link_rst_b)
        (state_reg == sbc_pkg::ST_ADDR_ACK && read_reg) |=>
        tx_reg == $past(rd_data) && state_reg == sbc_pkg::ST_RDATA;
    endproperty
    a_read_load: assert property (p_read_load) // [R4]
        else $error("read byte not loaded");

    property p_stop_halts;
        @(posedge ref_clk) disable iff (!rst_b)
        stop_s |=> !clk_ctl_reg.bus_clock_run;
    endproperty
    a_stop_halts: assert property (p_stop_halts) // [R16]
        else $error("bus clocks run during stop");

    property p_src_free;
        @(posedge ref_clk) disable iff (!rst_b)
        !cfg_s.b1[`SBC_B1_SRC_STOPPABLE] |=> clk_ctl_reg.src_run;
    endproperty
    a_src_free: assert property (p_src_free) // [R8]
        else $error("free running reference pair halted");

    property p_src_pd;
        @(posedge ref_clk) disable iff (!rst_b)
        (pd_s && cfg_s.b2[`SBC_B2_SRC_PD_TRI]) |=> !clk_ctl_reg.src_oe;
    endproperty
    a_src_pd: assert property (p_src_pd) // [R11]
        else $error("reference pair driven in power down");

    property p_cpu_off;
        @(posedge ref_clk) disable iff (!rst_b)
        (!cfg_s.b1[`SBC_B1_CPU_EN_LSB] ||
         (pd_s && cfg_s.b2[`SBC_B2_CPU_PD_TRI_LSB]))
        |=> !clk_ctl_reg.cpu_oe[0];
    endproperty
    a_cpu_off: assert property (p_cpu_off) // [R13]
        else $error("cpu pair 0 driven while off");

    property p_drive;
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(cfg_s.b0[`SBC_B0_DRIVE]) |=> clk_ctl_reg.bus_drive_high;
    endproperty
    a_drive: assert property (p_drive) // [R6]
        else $error("drive strength not followed");

    c_write: cover property (@(posedge smb_clk) disable iff (!link_rst_b)
        state_reg == sbc_pkg::ST_WDATA_ACK);
    c_read: cover property (@(posedge smb_clk) disable iff (!link_rst_b)
        state_reg == sbc_pkg::ST_RDATA_ACK);
    c_stop: cover property (@(posedge ref_clk) disable iff (!rst_b)
        $fell(clk_ctl_reg.bus_clock_run));

endmodule

// ---- hdl/sbc_pkg.sv ----
// types shared by the serial byte configuration port
package sbc_pkg;

    // link-side transaction states
    typedef enum logic [3:0] {
        ST_ADDR,
        ST_ADDR_ACK,
        ST_CMD,
        ST_CMD_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK,
        ST_IGNORE
    } sbc_state_t;

    // the three configuration bytes as one word
    typedef struct packed {
        logic [7:0] b2;
        logic [7:0] b1;
        logic [7:0] b0;
    } sbc_cfg_t;

    // clock output controls; cpu_oe[2] debug pair, [1] pair1, [0] pair0
    typedef struct packed {
        logic bus_drive_high;
        logic bus_clock_run;
        logic src_run;
        logic src_oe;
        logic cpu_run;
        logic [2:0] cpu_oe;
    } sbc_clk_ctl_t;

endpackage

// ---- hdl/sbc_sync2.sv ----
// two flip-flop level synchroniser
`timescale 1ns/1ns

module sbc_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule

// ---- verification/sbc_host_model.sv ----
// behavioural serial bus host that drives the configuration port
`timescale 1ns/1ns

module sbc_host_model (
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    localparam int HALF = 32;

    // bus idles released: clock high, data pulled up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // start or repeated start; long hold so the detector sees it
    task automatic start_cond();
        #3;
        #(HALF/2) sda_low = 1'b0;
        #(HALF/2) scl = 1'b1;
        #80 sda_low = 1'b1;
        #80 scl = 1'b0;
    endtask

    // stop, then the clock stands still until the next frame
    task automatic stop_cond();
        #(HALF/2) sda_low = 1'b1;
        #(HALF/2) scl = 1'b1;
        #80 sda_low = 1'b0;
        #80;
    endtask

    // data changes only in the low half, line sampled at rising clock
    task automatic clock_bit(input logic b, output logic got);
        #(HALF/2) sda_low = ~b;
        #(HALF/2) scl = 1'b1;
        got = sda_line;
        #HALF scl = 1'b0;
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic got;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], got);
        end
        clock_bit(1'b1, got);
        ack = ~got;
    endtask

    // byte write: address, command 100xxxxx, one data byte
    task automatic write_frame(input logic [7:0] addr,
                               input logic [7:0] cmd,
                               input logic [7:0] data,
                               output logic [2:0] acks);
        start_cond();
        send_byte(addr, acks[2]);
        send_byte(cmd, acks[1]);
        send_byte(data, acks[0]);
        stop_cond();
    endtask

    // byte read with repeated start; host acks the byte then stops
    task automatic read_frame(input logic [7:0] cmd,
                              output logic [7:0] d,
                              output logic [2:0] acks);
        logic got;
        start_cond();
        send_byte(8'hD2, acks[2]);
        send_byte(cmd, acks[1]);
        start_cond();
        send_byte(8'hD3, acks[0]);
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, got);
            d[i] = got;
        end
        clock_bit(1'b0, got);
        stop_cond();
    endtask
endmodule

// ---- verification/testbench.sv ----
// self-checking bench of the serial byte configuration port
`timescale 1ns/1ns

module testbench;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic smb_clk, sda_low, sda_in, sda_out, sda_oe;
    logic strap_a, strap_b, pd, stop;
    logic lat_a, lat_b;
    sbc_pkg::sbc_clk_ctl_t clk_ctl, exp_ctl;
    int num_errors = 0;
    int n_compared = 0;
    logic [7:0] cfg [0:2];
    logic [7:0] rd, val;
    logic [2:0] acks;
    int idx;

    always #4 ref_clk = ~ref_clk;
    // open-drain line with pull-up: the port pulls low only when it
    // enables a low output level
    assign sda_in = ~(sda_low | (sda_oe & ~sda_out));

    sbc_host_model host_u (.sda_line(sda_in), .scl(smb_clk),
                           .sda_low(sda_low));
    sbc_config_port dut_u (.ref_clk(ref_clk), .rst_b(rst_b),
        .smb_clk(smb_clk), .sda_in(sda_in), .sda_out(sda_out),
        .sda_oe(sda_oe), .freq_strap_first(strap_a),
        .freq_strap_second(strap_b), .power_down(pd),
        .software_bus_clock_stop(stop), .clk_ctl(clk_ctl));

    task automatic end_sim();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t byte got %h exp %h", $time, got, exp);
        end
    endtask

    // model of a stored byte: reserved bits fixed, straps read back
    function automatic logic [7:0] merge(input int i, input logic [7:0] v);
        case (i)
            0: return (v & 8'h40) | 8'h0C | {6'h00, lat_b, lat_a};
            1: return (v & 8'hC7) | 8'h38;
            default: return v & 8'hF8;
        endcase
    endfunction

    // expected output controls; compared after the 3-cycle crossing
    task automatic check_ctl();
        exp_ctl.bus_drive_high = cfg[0][6];
        exp_ctl.bus_clock_run = ~stop;
        exp_ctl.src_run = ~(stop & cfg[1][7]);
        exp_ctl.src_oe = cfg[1][6] & ~(pd & cfg[2][7])
                         & ~(stop & cfg[1][7] & cfg[2][6]);
        exp_ctl.cpu_run = ~pd;
        exp_ctl.cpu_oe = cfg[1][2:0] & ~({3{pd}} & cfg[2][5:3]);
        repeat (4) @(negedge ref_clk);
        n_compared++;
        if (clk_ctl !== exp_ctl) begin
            num_errors++;
            $display("MISMATCH %0t controls got %h exp %h", $time,
                     clk_ctl, exp_ctl);
        end
    endtask

    task automatic do_reset();
        // straps stay put through reset, so these are the caught values
        lat_a = strap_a;
        lat_b = strap_b;
        rst_b = 1'b0;
        repeat (16) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (12) @(negedge ref_clk);
        cfg[0] = merge(0, 8'h40);
        cfg[1] = merge(1, 8'h47);
        cfg[2] = merge(2, 8'h00);
    endtask

    task automatic check_all();
        for (int i = 0; i < 3; i++) begin
            host_u.read_frame(8'h80 | 8'(i), rd, acks);
            cmp8({5'h00, acks}, 8'h07);
            cmp8(rd, cfg[i]);
        end
        check_ctl();
    endtask

    // overall limit on the run
    initial begin
        #700000;
        num_errors++;
        $display("MISMATCH %0t run did not finish", $time);
        end_sim();
    end

    initial begin
        void'($urandom(32'h9639));
        strap_a = 1'($urandom);
        strap_b = 1'($urandom);
        pd = 1'b0;
        stop = 1'b0;
        do_reset();
        check_all();
        // random writes and reads, unmapped index 3 included
        repeat (16) begin
            idx = $urandom_range(0, 3);
            val = 8'($urandom);
            // host keeps reserved bits at their fixed values
            case (idx)
                0: val = (val & 8'h43) | 8'h0C;
                1: val = (val & 8'hC7) | 8'h38;
                2: val = val & 8'hF8;
                default: ;
            endcase
            host_u.write_frame(8'hD2, 8'h80 | 8'(idx), val, acks);
            cmp8({5'h00, acks}, 8'h07);
            if (idx < 3) cfg[idx] = merge(idx, val);
            host_u.read_frame(8'h80 | 8'(idx), rd, acks);
            cmp8(rd, (idx < 3) ? cfg[idx] : 8'h00);
            @(negedge ref_clk);
            pd = 1'($urandom);
            stop = 1'($urandom);
            // strap pins may move after power-up; byte 0 must not follow
            strap_a = 1'($urandom);
            strap_b = 1'($urandom);
            check_ctl();
        end
        // foreign address and block command are refused
        host_u.write_frame(8'hA4, 8'h81, 8'h00, acks);
        cmp8({5'h00, acks}, 8'h00);
        host_u.write_frame(8'hD2, 8'h01, 8'h00, acks);
        cmp8({5'h00, acks}, 8'h04);
        check_all();
        do_reset();
        check_all();
        end_sim();
    end
endmodule
